// >>> i2c_host_bus_sequencer.sv
// I2C host bus sequencer with AXI4-Lite register slave
//
// How it works
// - Start: both lines high, load reload bits 7:0, timeout with both high drives SDA
// - Then reload; next timeout clears start request, holds SDA low, counter stops
// - Lines low at start, or SCL low early: collision flag, abort, idle
// - Released SCL: counter reloads while SCL reads low, counts down once SCL seen high
// - Buffer write during any sequence is dropped and sets write collision
// - Repeated start bit ignores writes until Start has completed
// - Repeated start accepted only when the state machine is idle
// - Repeated start: SCL low, SDA released, SCL up, SDA low, SCL low
// - Repeated start sets start flag when SDA falls with SCL high, interrupt flag after timeout
// - Repeated start collision: SDA low at SCL rise, or SCL falls early
// - Idle buffer write sets buffer full and starts transmission
// - SDA changes after SCL low; low and high each one baud period
// - Eighth falling edge clears buffer full and releases SDA
// - Ninth clock samples SDA into acknowledge status
// - After ninth clock: interrupt flag, SCL held low, wait for next byte
// - Interrupt flag on each completed start, repeated start, byte
// - No event queueing; early buffer write dropped with write collision
// - Host mode interrupts when a start, repeated start or byte completes, not on line detection
// - Start and stop detected flags clear on reset and port disable
// - Firmware host mode: only start/stop detection, software drives lines
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "i2c_seq_defs.svh"
module i2c_host_bus_sequencer
  import i2c_seq_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [7:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_OUT
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sda_sync_reg;
  logic [1:0] scl_sync_reg;
  logic       sda_prev_reg;
  logic       scl_prev_reg;
  logic       sda_s;
  logic       scl_s;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sda_sync_reg <= 2'h3;
      scl_sync_reg <= 2'h3;
      sda_prev_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
      scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
      sda_prev_reg <= sda_sync_reg[1];
      scl_prev_reg <= scl_sync_reg[1];
    end
  end
  assign sda_s = sda_sync_reg[1];
  assign scl_s = scl_sync_reg[1];

  // ---------------------------------------------------------------
  // Registers and shared state
  // ---------------------------------------------------------------
  logic [7:0]  first_control_reg;
  logic [7:0]  baud_reload_reg;
  logic [7:0]  transmit_buffer;
  logic [7:0]  shift_register;
  logic [7:0]  baud_counter;
  logic [3:0]  bit_cnt_reg;
  logic        start_request_bit;
  logic        repeated_start_request_bit;
  logic        ack_status_bit;
  logic        buffer_full_flag;
  logic        write_collision_flag;
  logic        bus_collision_flag;
  logic        port_interrupt_flag;
  logic        start_seen_reg;
  logic        stop_seen_reg;
  logic        start_done_reg;
  logic        sw_sda_reg;
  logic        sw_scl_reg;
  seq_state_t  state_reg;

  logic        port_enable_bit;
  logic [3:0]  port_mode_select;
  logic        hw_host;
  logic        fw_host;
  logic        timeout;
  logic        start_line;
  logic        stop_line;

  assign port_enable_bit  = first_control_reg[`CTRL1_EN_BIT];
  assign port_mode_select = first_control_reg[`CTRL1_MODE_LSB +: 4];
  assign hw_host    = port_enable_bit && port_mode_select == `MODE_HW_HOST;
  assign fw_host    = port_enable_bit && port_mode_select == `MODE_FW_HOST;
  assign timeout    = baud_counter == 8'h00;
  assign start_line = scl_s && sda_prev_reg && !sda_s;
  assign stop_line  = scl_s && !sda_prev_reg && sda_s;

  // ---------------------------------------------------------------
  // AXI4-Lite handshake
  // ---------------------------------------------------------------
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        wr_lane0;

  assign wr_fire  = aw_got_reg && w_got_reg && !BVALID_OUT;
  assign wr_lane0 = wr_fire && w_strb_reg[0];

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
      BVALID_OUT  <= 1'b0;
      BRESP_OUT   <= `RESP_OKAY;
    end else begin
      AWREADY_OUT <= !aw_got_reg && !AWREADY_OUT && !BVALID_OUT;
      WREADY_OUT  <= !w_got_reg && !WREADY_OUT && !BVALID_OUT;
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= AWADDR_IN;
        AWREADY_OUT <= 1'b0;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= WDATA_IN;
        w_strb_reg <= WSTRB_IN;
        WREADY_OUT <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        BVALID_OUT <= 1'b1;
        if (aw_addr_reg > `OFS_PINS || aw_addr_reg[1:0] != 2'h0) begin
          BRESP_OUT <= `RESP_SLVERR;
        end else begin
          BRESP_OUT <= `RESP_OKAY;
        end
      end else if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0;
      RRESP_OUT   <= `RESP_OKAY;
    end else begin
      ARREADY_OUT <= !ARREADY_OUT && !RVALID_OUT;
      if (ARVALID_IN && ARREADY_OUT) begin
        ARREADY_OUT <= 1'b0;
        RVALID_OUT  <= 1'b1;
        RRESP_OUT   <= `RESP_OKAY;
        if (ARADDR_IN == `OFS_CTRL1) begin
          RDATA_OUT <= {24'h0, first_control_reg};
        end else if (ARADDR_IN == `OFS_SEQ) begin
          RDATA_OUT <= {25'h0, ack_status_bit, 4'h0,
                        repeated_start_request_bit, start_request_bit};
        end else if (ARADDR_IN == `OFS_STATUS) begin
          RDATA_OUT <= {21'h0, bus_collision_flag, write_collision_flag,
                        port_interrupt_flag, 3'h0, stop_seen_reg,
                        start_seen_reg, 2'h0, buffer_full_flag};
        end else if (ARADDR_IN == `OFS_TXBUF) begin
          RDATA_OUT <= {24'h0, transmit_buffer};
        end else if (ARADDR_IN == `OFS_RELOAD) begin
          RDATA_OUT <= {24'h0, baud_reload_reg};
        end else if (ARADDR_IN == `OFS_PINS) begin
          RDATA_OUT <= {28'h0, scl_s, sda_s, sw_scl_reg, sw_sda_reg};
        end else begin
          RDATA_OUT <= 32'h0;
          RRESP_OUT <= `RESP_SLVERR;
        end
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Plain control registers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      first_control_reg <= 8'h00;
      baud_reload_reg   <= `RELOAD_RESET;
      sw_sda_reg        <= 1'b1;
      sw_scl_reg        <= 1'b1;
    end else if (wr_lane0) begin
      if (aw_addr_reg == `OFS_CTRL1) begin
        first_control_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == `OFS_RELOAD) begin
        baud_reload_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == `OFS_PINS) begin
        sw_sda_reg <= w_data_reg[0];
        sw_scl_reg <= w_data_reg[1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic wr_seq;
  logic wr_buf;
  logic wr_status;
  assign wr_seq    = wr_lane0 && aw_addr_reg == `OFS_SEQ;
  assign wr_buf    = wr_lane0 && aw_addr_reg == `OFS_TXBUF;
  assign wr_status = wr_fire && w_strb_reg[1] &&
                     aw_addr_reg == `OFS_STATUS;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_reg                  <= ST_IDLE;
      baud_counter               <= 8'h00;
      bit_cnt_reg                <= 4'h0;
      shift_register             <= 8'h00;
      transmit_buffer            <= 8'h00;
      start_request_bit          <= 1'b0;
      repeated_start_request_bit <= 1'b0;
      ack_status_bit             <= 1'b0;
      buffer_full_flag           <= 1'b0;
      write_collision_flag       <= 1'b0;
      bus_collision_flag         <= 1'b0;
      port_interrupt_flag        <= 1'b0;
      start_done_reg             <= 1'b0;
      SDA_OE_OUT                 <= 1'b0;
      SCL_OE_OUT                 <= 1'b0;
    end else begin
      // Software clears sticky flags by writing one; a same-cycle set wins
      if (wr_status) begin
        if (w_data_reg[`ST_IF_BIT])   port_interrupt_flag  <= 1'b0;
        if (w_data_reg[`ST_WRITE_COLLISION_FLAG_BIT]) write_collision_flag <= 1'b0;
        if (w_data_reg[`ST_BCL_BIT])  bus_collision_flag   <= 1'b0;
      end
      if (baud_counter != 8'h00) begin
        baud_counter <= baud_counter - 8'h01;
      end
      // Buffer writes
      if (wr_buf) begin
        if (state_reg != ST_IDLE || start_request_bit ||
            repeated_start_request_bit || !start_done_reg) begin
          write_collision_flag <= 1'b1;
        end else if (hw_host) begin
          transmit_buffer  <= w_data_reg[7:0];
          shift_register   <= w_data_reg[7:0];
          buffer_full_flag <= 1'b1;
          SCL_OE_OUT       <= 1'b1;
          bit_cnt_reg      <= 4'h0;
          baud_counter     <= baud_reload_reg;
          state_reg        <= ST_TLOW;
        end
      end
      // Request bits
      if (wr_seq && hw_host && state_reg == ST_IDLE) begin
        if (w_data_reg[`SEQ_SEN_BIT] && !start_request_bit) begin
          start_request_bit <= 1'b1;
          if (scl_s && sda_s) begin
            baud_counter <= baud_reload_reg;
            state_reg    <= ST_SWAIT;
          end else begin
            start_request_bit  <= 1'b0;
            bus_collision_flag <= 1'b1;
          end
        end else if (w_data_reg[`SEQ_REPEATED_START_REQUEST_BIT_BIT] && start_done_reg) begin
          repeated_start_request_bit <= 1'b1;
          SCL_OE_OUT   <= 1'b1;
          baud_counter <= baud_reload_reg;
          state_reg    <= ST_RLOW;
        end
      end
      case (state_reg)
        ST_IDLE: begin
        end
        ST_SWAIT: begin
          if (!scl_s) begin
            bus_collision_flag <= 1'b1;
            start_request_bit  <= 1'b0;
            state_reg          <= ST_IDLE;
          end else if (timeout && sda_s) begin
            SDA_OE_OUT   <= 1'b1;
            baud_counter <= baud_reload_reg;
            state_reg    <= ST_SHOLD;
          end
        end
        ST_SHOLD: begin
          if (timeout) begin
            start_request_bit   <= 1'b0;
            start_done_reg      <= 1'b1;
            port_interrupt_flag <= 1'b1;
            state_reg           <= ST_IDLE;
          end
        end
        ST_RLOW: begin
          // SDA released only once SCL is already pulled low
          SDA_OE_OUT <= 1'b0;
          if (scl_s) begin
            baud_counter <= baud_reload_reg;
          end else if (timeout && sda_s) begin
            SCL_OE_OUT <= 1'b0;
            state_reg  <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          if (scl_s && !scl_prev_reg && !sda_s) begin
            bus_collision_flag         <= 1'b1;
            repeated_start_request_bit <= 1'b0;
            state_reg                  <= ST_IDLE;
          end else if (!scl_s) begin
            baud_counter <= baud_reload_reg;
          end else if (timeout) begin
            SDA_OE_OUT   <= 1'b1;
            baud_counter <= baud_reload_reg;
            state_reg    <= ST_RSDA;
          end
        end
        ST_RSDA: begin
          if (!scl_s && !SCL_OE_OUT) begin
            bus_collision_flag         <= 1'b1;
            repeated_start_request_bit <= 1'b0;
            state_reg                  <= ST_IDLE;
          end else if (timeout) begin
            SCL_OE_OUT                 <= 1'b1;
            repeated_start_request_bit <= 1'b0;
            port_interrupt_flag        <= 1'b1;
            state_reg                  <= ST_IDLE;
          end
        end
        ST_TLOW: begin
          SCL_OE_OUT <= 1'b1;
          // Data moves only after SCL was low for a cycle
          if (SCL_OE_OUT && bit_cnt_reg < 4'h8) begin
            SDA_OE_OUT <= !shift_register[7];
          end else if (SCL_OE_OUT) begin
            SDA_OE_OUT <= 1'b0;
          end
          if (timeout) begin
            SCL_OE_OUT   <= 1'b0;
            baud_counter <= baud_reload_reg;
            state_reg    <= ST_THIGH;
          end
        end
        ST_THIGH: begin
          if (!scl_s) begin
            baud_counter <= baud_reload_reg;
          end else if (timeout) begin
            SCL_OE_OUT   <= 1'b1;
            baud_counter <= baud_reload_reg;
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            shift_register <= {shift_register[6:0], 1'b0};
            if (bit_cnt_reg == 4'h7) begin
              buffer_full_flag <= 1'b0;
            end
            if (bit_cnt_reg == 4'h8) begin
              ack_status_bit      <= sda_s;
              port_interrupt_flag <= 1'b1;
              baud_counter        <= 8'h00;
              state_reg           <= ST_IDLE;
            end else begin
              state_reg <= ST_TLOW;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (!hw_host) begin
        state_reg                  <= ST_IDLE;
        start_request_bit          <= 1'b0;
        repeated_start_request_bit <= 1'b0;
        start_done_reg             <= 1'b0;
        SDA_OE_OUT                 <= fw_host && !sw_sda_reg;
        SCL_OE_OUT                 <= fw_host && !sw_scl_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Start and stop detection
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
    end else if (!port_enable_bit) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
    end else if (start_line) begin
      start_seen_reg <= 1'b1;
      stop_seen_reg  <= 1'b0;
    end else if (stop_line) begin
      stop_seen_reg  <= 1'b1;
      start_seen_reg <= 1'b0;
    end
  end

  // Lines only ever pulled low
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SDA_OUT <= 1'b0;
      SCL_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
      SCL_OUT <= 1'b0;
    end
  end

endmodule // i2c_host_bus_sequencer

// >>> i2c_seq_defs.svh
// Register offsets, field positions and reset values of the sequencer
`ifndef I2C_SEQ_DEFS_SVH
`define I2C_SEQ_DEFS_SVH
`define OFS_CTRL1      8'h00
`define OFS_SEQ        8'h04
`define OFS_STATUS     8'h08
`define OFS_TXBUF      8'h0c
`define OFS_RELOAD     8'h10
`define OFS_PINS       8'h14
`define CTRL1_EN_BIT   5
`define CTRL1_MODE_LSB 0
`define MODE_HW_HOST   4'h8
`define MODE_FW_HOST   4'hb
`define SEQ_SEN_BIT    0
`define SEQ_REPEATED_START_REQUEST_BIT_BIT   1
`define SEQ_PEN_BIT    2
`define SEQ_ACKST_BIT  6
`define ST_BF_BIT      0
`define ST_S_BIT       3
`define ST_P_BIT       4
`define ST_IF_BIT      8
`define ST_WRITE_COLLISION_FLAG_BIT    9
`define ST_BCL_BIT     10
`define RELOAD_RESET   8'h04
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// >>> i2c_seq_pkg.sv
// Types of the sequencer
package i2c_seq_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SWAIT = 8'h02,
    ST_SHOLD = 8'h04,
    ST_RLOW  = 8'h08,
    ST_RHIGH = 8'h10,
    ST_RSDA  = 8'h20,
    ST_TLOW  = 8'h40,
    ST_THIGH = 8'h80
  } seq_state_t;
endpackage

// >>> i2c_seq_checker_assertions.sv
// Port-level checker for the host bus sequencer
`timescale 1ns/1ps
module i2c_seq_checker (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        AWVALID_IN,
  input  wire logic        AWREADY_OUT,
  input  wire logic        WVALID_IN,
  input  wire logic        WREADY_OUT,
  input  wire logic [1:0]  BRESP_OUT,
  input  wire logic        BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic        ARVALID_IN,
  input  wire logic        ARREADY_OUT,
  input  wire logic [31:0] RDATA_OUT,
  input  wire logic        RVALID_OUT,
  input  wire logic        RREADY_IN,
  input  wire logic        SDA_OUT,
  input  wire logic        SDA_OE_OUT,
  input  wire logic        SCL_IN,
  input  wire logic        SCL_OUT,
  input  wire logic        SCL_OE_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  chk_lines_low_only: assert property (!SDA_OUT && !SCL_OUT)
    else $error("bus line driven high");
  chk_b_follows_w: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN
    && WREADY_OUT |-> ##2 BVALID_OUT) else $error("write response late");
  chk_b_holds: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT
    && $stable(BRESP_OUT)) else $error("write response dropped");
  chk_r_follows_ar: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("read response late");
  chk_r_holds: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT
    && $stable(RDATA_OUT)) else $error("read data dropped");
  chk_ready_blocked: assert property ((BVALID_OUT |-> !AWREADY_OUT
    && !WREADY_OUT) and (RVALID_OUT |-> !ARREADY_OUT))
    else $error("ready while response pending");
  chk_sda_release_low: assert property ($fell(SDA_OE_OUT) |->
    $past(SCL_OE_OUT)) else $error("data released with clock high");
  chk_scl_low_time: assert property ($rose(SCL_OE_OUT) |->
    SCL_OE_OUT[*3]) else $error("clock low too short");
  chk_scl_high_time: assert property ($rose(SCL_IN) && !SCL_OE_OUT |->
    (!SCL_OE_OUT)[*3]) else $error("clock high too short");
  cover property ($rose(SDA_OE_OUT) && !SCL_OE_OUT);
  cover property ($fell(SCL_OE_OUT));
  cover property (RVALID_OUT && RREADY_IN);
endmodule // i2c_seq_checker

bind i2c_host_bus_sequencer i2c_seq_checker i_chk (.*);

// >>> i2c_client_model.sv
// Behavioural client device on the serial bus
`timescale 1ns/1ps
module i2c_client_model (
  input  wire logic sda_in,
  input  wire logic scl_in,
  input  wire logic nack_in,
  input  wire logic stretch_in,
  input  wire logic jam_in,
  output logic      sda_oe_out,
  output logic      scl_oe_out,
  output logic [7:0] rx_byte_out,
  output logic [7:0] starts_out
);
  logic [3:0] bit_cnt;
  logic       ack_oe;
  logic       str_oe;
  initial begin
    bit_cnt = 4'h0;
    ack_oe = 1'b0;
    str_oe = 1'b0;
    rx_byte_out = 8'h00;
    starts_out = 8'h00;
  end
  // Open drain: only pull low, pull-up gives the high level
  assign sda_oe_out = ack_oe | jam_in;
  assign scl_oe_out = str_oe | jam_in;
  always @(negedge sda_in) if (scl_in && !jam_in) begin
    starts_out = starts_out + 8'h01;
    bit_cnt = 4'h0;
    ack_oe = 1'b0;
  end
  always @(posedge scl_in) begin
    if (bit_cnt < 4'h8) rx_byte_out = {rx_byte_out[6:0], sda_in};
    bit_cnt = bit_cnt + 4'h1;
  end
  always @(negedge scl_in) begin
    if (bit_cnt == 4'h8) ack_oe = !nack_in;
    else if (bit_cnt == 4'h9) begin
      ack_oe = 1'b0;
      bit_cnt = 4'h0;
    end
  end
  // Slow client holds the clock low after each falling edge
  always @(negedge scl_in) if (stretch_in && !jam_in) begin
    str_oe = 1'b1;
    #2000 str_oe = 1'b0;
  end
endmodule // i2c_client_model

// >>> i2c_host_bus_sequencer_tb_top.sv
// Self-checking testbench for the host bus sequencer
`timescale 1ns/1ps
`include "i2c_seq_defs.svh"
module i2c_host_bus_sequencer_tb_top;
  logic        CORE_CLK_IN, RST_B_IN, AWVALID_IN, WVALID_IN, BREADY_IN;
  logic        ARVALID_IN, RREADY_IN, AWREADY_OUT, WREADY_OUT, BVALID_OUT;
  logic        ARREADY_OUT, RVALID_OUT, SDA_OUT, SDA_OE_OUT, SCL_OUT;
  logic        SCL_OE_OUT, nack, stretch, jam, p_sda_oe, p_scl_oe;
  logic [7:0]  AWADDR_IN, ARADDR_IN, rx, starts;
  logic [3:0]  WSTRB_IN;
  logic [1:0]  BRESP_OUT, RRESP_OUT;
  logic [31:0] WDATA_IN, RDATA_OUT;
  int          num_errors, checks_done;
  wire         sda_w = !(SDA_OE_OUT | p_sda_oe);
  wire         scl_w = !(SCL_OE_OUT | p_scl_oe);
  always #25 CORE_CLK_IN = ~CORE_CLK_IN;
  i2c_host_bus_sequencer i_i2c_host_bus_sequencer (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
    .AWADDR_IN(AWADDR_IN), .AWVALID_IN(AWVALID_IN),
    .AWREADY_OUT(AWREADY_OUT), .WDATA_IN(WDATA_IN), .WSTRB_IN(WSTRB_IN),
    .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT), .BRESP_OUT(BRESP_OUT),
    .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN), .ARADDR_IN(ARADDR_IN),
    .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
    .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT),
    .RREADY_IN(RREADY_IN), .SDA_IN(sda_w), .SDA_OUT(SDA_OUT),
    .SDA_OE_OUT(SDA_OE_OUT), .SCL_IN(scl_w), .SCL_OUT(SCL_OUT),
    .SCL_OE_OUT(SCL_OE_OUT));
  i2c_client_model i_i2c_client_model (.sda_in(sda_w), .scl_in(scl_w),
    .nack_in(nack), .stretch_in(stretch), .jam_in(jam),
    .sda_oe_out(p_sda_oe), .scl_oe_out(p_scl_oe), .rx_byte_out(rx),
    .starts_out(starts));
  // --------------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic timeout(input string nm);
    num_errors++;
    $display("MISMATCH %s expected done seen timeout", nm);
    close_out();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CORE_CLK_IN);
    AWADDR_IN <= a;
    WDATA_IN <= d;
    AWVALID_IN <= 1'b1;
    WVALID_IN <= 1'b1;
    BREADY_IN <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CORE_CLK_IN);
      if (AWREADY_OUT) AWVALID_IN <= 1'b0;
      if (WREADY_OUT) WVALID_IN <= 1'b0;
      if (BVALID_OUT) break;
    end
    BREADY_IN <= 1'b0;
    if (n == 50) timeout("write");
    check("bresp", {30'h0, BRESP_OUT}, {30'h0, `RESP_OKAY});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge CORE_CLK_IN);
    ARADDR_IN <= a;
    ARVALID_IN <= 1'b1;
    RREADY_IN <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CORE_CLK_IN);
      if (ARREADY_OUT) ARVALID_IN <= 1'b0;
      if (RVALID_OUT) break;
    end
    d = RDATA_OUT;
    r = RRESP_OUT;
    RREADY_IN <= 1'b0;
    if (n == 50) timeout("read");
  endtask
  task automatic exp_bit(input logic [7:0] a, input int b, input logic e,
                         input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(nm, {31'h0, d[b]}, {31'h0, e});
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] d;
    logic [1:0]  r;
    for (int n = 0; n < 400; n++) begin
      axi_rd(a, d, r);
      if (d[b] === 1'b1) return;
    end
    timeout("poll");
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(`OFS_RELOAD, d, r);
    check("reload_rst", d, {24'h0, `RELOAD_RESET});
    axi_rd(8'h40, d, r);
    check("bad_resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    check("bad_data", d, 32'h0);
    axi_rd(`OFS_STATUS, d, r);
    check("status_rst", d, 32'h0);
    axi_wr(`OFS_RELOAD, 32'h2);
    axi_rd(`OFS_RELOAD, d, r);
    check("reload_wr", d, 32'h2);
  endtask
  task automatic t_early;
    axi_wr(`OFS_CTRL1, 32'h28); // Enable, hardware host mode
    axi_wr(`OFS_TXBUF, 32'h55);
    exp_bit(`OFS_STATUS, `ST_WRITE_COLLISION_FLAG_BIT, 1'b1, "write_collision_flag_early");
    exp_bit(`OFS_STATUS, `ST_BF_BIT, 1'b0, "bf_early");
    axi_wr(`OFS_SEQ, 32'h2);
    exp_bit(`OFS_SEQ, `SEQ_REPEATED_START_REQUEST_BIT_BIT, 1'b0, "repeated_start_request_bit_early");
    check("lines_idle", {30'h0, SCL_OE_OUT, SDA_OE_OUT}, 32'h0);
    axi_wr(`OFS_STATUS, 32'h200);
  endtask
  task automatic t_start;
    axi_wr(`OFS_SEQ, 32'h1);
    poll(`OFS_STATUS, `ST_IF_BIT);
    exp_bit(`OFS_SEQ, `SEQ_SEN_BIT, 1'b0, "sen_clr");
    exp_bit(`OFS_STATUS, `ST_S_BIT, 1'b1, "start_seen");
    check("sda_held", {31'h0, SDA_OE_OUT}, 32'h1);
    check("starts", {24'h0, starts}, 32'h1);
    axi_wr(`OFS_STATUS, 32'h100);
  endtask
  task automatic t_byte(input logic [7:0] b, input logic nk, st);
    nack <= nk;
    stretch <= st;
    axi_wr(`OFS_TXBUF, {24'h0, b});
    exp_bit(`OFS_STATUS, `ST_BF_BIT, 1'b1, "bf_set");
    axi_wr(`OFS_TXBUF, 32'hff);
    exp_bit(`OFS_STATUS, `ST_WRITE_COLLISION_FLAG_BIT, 1'b1, "write_collision_flag_busy");
    poll(`OFS_STATUS, `ST_IF_BIT);
    exp_bit(`OFS_STATUS, `ST_BF_BIT, 1'b0, "bf_clr");
    exp_bit(`OFS_SEQ, `SEQ_ACKST_BIT, nk, "ack_stat");
    check("rx_byte", {24'h0, rx}, {24'h0, b});
    check("scl_held", {30'h0, SCL_OE_OUT, SDA_OE_OUT}, 32'h2);
    axi_wr(`OFS_STATUS, 32'h300);
    stretch <= 1'b0;
  endtask
  task automatic t_rstart;
    axi_wr(`OFS_SEQ, 32'h2);
    poll(`OFS_STATUS, `ST_IF_BIT);
    exp_bit(`OFS_SEQ, `SEQ_REPEATED_START_REQUEST_BIT_BIT, 1'b0, "repeated_start_request_bit_clr");
    exp_bit(`OFS_STATUS, `ST_S_BIT, 1'b1, "rs_seen");
    check("starts", {24'h0, starts}, 32'h2);
    check("rs_lines", {30'h0, SCL_OE_OUT, SDA_OE_OUT}, 32'h3);
    axi_wr(`OFS_STATUS, 32'h100);
  endtask
  task automatic t_coll;
    axi_wr(`OFS_CTRL1, 32'h08);
    exp_bit(`OFS_STATUS, `ST_S_BIT, 1'b0, "s_clr_dis");
    axi_wr(`OFS_CTRL1, 32'h28);
    jam <= 1'b1;
    axi_wr(`OFS_SEQ, 32'h1);
    poll(`OFS_STATUS, `ST_BCL_BIT);
    exp_bit(`OFS_SEQ, `SEQ_SEN_BIT, 1'b0, "sen_abort");
    check("coll_idle", {30'h0, SCL_OE_OUT, SDA_OE_OUT}, 32'h0);
    jam <= 1'b0;
  endtask
  task automatic t_fw;
    axi_wr(`OFS_CTRL1, 32'h2b); // Enable, firmware host mode
    axi_wr(`OFS_PINS, 32'h2);
    exp_bit(`OFS_PINS, 0, 1'b0, "fw_sda_sw");
    check("fw_lines", {30'h0, SCL_OE_OUT, SDA_OE_OUT}, 32'h1);
    exp_bit(`OFS_STATUS, `ST_S_BIT, 1'b1, "fw_start");
  endtask
  initial begin
    CORE_CLK_IN = 1'b0;
    RST_B_IN = 1'b0;
    {AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN} = 5'h00;
    {AWADDR_IN, ARADDR_IN, WDATA_IN} = 48'h0;
    WSTRB_IN = 4'hf;
    {nack, stretch, jam} = 3'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge CORE_CLK_IN);
    RST_B_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    t_regs();
    t_early();
    t_start();
    t_byte(8'ha4, 1'b0, 1'b0);
    t_byte(8'h3c, 1'b1, 1'b1);
    t_rstart();
    t_coll();
    t_fw();
    close_out();
  end
endmodule // i2c_host_bus_sequencer_tb_top
